// File: core/frtc_pkg.sv
// constants for the free-run timer with four input capture channels
package frtc_pkg;
  // register byte offsets
  localparam logic [7:0] FRTC_OFS_CTRL_LO   = 8'h00;
  localparam logic [7:0] FRTC_OFS_CTRL_HI   = 8'h04;
  localparam logic [7:0] FRTC_OFS_COUNT     = 8'h08;
  localparam logic [7:0] FRTC_OFS_CAP_CTL_A = 8'h0C;
  localparam logic [7:0] FRTC_OFS_CAP_CTL_B = 8'h10;
  localparam logic [7:0] FRTC_OFS_CAP_EDG_A = 8'h14;
  localparam logic [7:0] FRTC_OFS_CAP_EDG_B = 8'h18;
  localparam logic [7:0] FRTC_OFS_CAP_VAL0  = 8'h1C;
  localparam logic [7:0] FRTC_OFS_CAP_VAL1  = 8'h20;
  localparam logic [7:0] FRTC_OFS_CAP_VAL2  = 8'h24;
  localparam logic [7:0] FRTC_OFS_CAP_VAL3  = 8'h28;
  // timer_ctrl_status_low fields
  localparam int FRTC_BIT_OVF   = 7;
  localparam int FRTC_BIT_OVFE  = 6;
  localparam int FRTC_BIT_STOP  = 5;
  localparam int FRTC_BIT_CLR   = 3;
  localparam int FRTC_LSB_CKSEL = 0;
  // timer_ctrl_status_high field
  localparam int FRTC_BIT_EXT_CLK = 15;
  // capture control pair fields, j = channel within pair
  localparam int FRTC_LSB_FLAG  = 6;
  localparam int FRTC_LSB_IE    = 4;
  localparam int FRTC_LSB_EDGE  = 0;
  // capture edge pair fields
  localparam int FRTC_LSB_POL   = 0;
  localparam int FRTC_LSB_SRC   = 2;
  // edge select codes
  localparam logic [1:0] FRTC_EDGE_NONE = 2'h0;
  localparam logic [1:0] FRTC_EDGE_RISE = 2'h1;
  localparam logic [1:0] FRTC_EDGE_FALL = 2'h2;
  localparam logic [1:0] FRTC_EDGE_BOTH = 2'h3;
  // reset values and widths
  localparam logic [15:0] FRTC_COUNT_RST = 16'h0000;
  localparam logic [15:0] FRTC_COUNT_MAX = 16'hFFFF;
  localparam logic [2:0]  FRTC_CKSEL_RST = 3'h0;
  localparam int          FRTC_CH_NUM   = 4;
  localparam int          FRTC_LIN_NUM  = 2;
  localparam logic [1:0]  FRTC_HTRANS_NONSEQ = 2'h2;
endpackage

// File: core/frtc_capture_chan.sv
// one input capture channel: synchroniser, edge detect, capture, flag
`timescale 1ns/100ps
module frtc_capture_chan
  import frtc_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         pin_in,
  input  wire logic         lin_in,
  input  wire logic         use_lin,
  input  wire logic [1:0]   edge_sel,
  input  wire logic [W-1:0] count,
  input  wire logic         flag_clr,
  output logic              flag,
  output logic [W-1:0]      cap_value,
  output logic              edge_pol,
  output logic              hit
);
  logic pin_s1;
  logic pin_s2;
  logic lin_s1;
  logic lin_s2;
  logic prev;
  logic sel;
  logic rise;
  logic fall;
  logic         next_flag;
  logic [W-1:0] next_cap_value;
  logic         next_edge_pol;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    sel  = use_lin ? lin_s2 : pin_s2;         // R12 R13 R14
    rise = sel & ~prev;                        // R20
    fall = ~sel & prev;                        // R20
    case (edge_sel)                            // R8
      FRTC_EDGE_RISE: hit = rise;
      FRTC_EDGE_FALL: hit = fall;
      FRTC_EDGE_BOTH: hit = rise | fall;
      default:        hit = 1'b0;
    endcase
    next_cap_value = hit ? count : cap_value;  // R7 R19
    next_edge_pol  = hit ? rise : edge_pol;    // R12
    // a new edge wins over a clear in the same cycle
    next_flag      = hit | (flag & ~flag_clr); // R7 R18
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1    <= 1'b0;
      pin_s2    <= 1'b0;
      lin_s1    <= 1'b0;
      lin_s2    <= 1'b0;
      prev      <= 1'b0;
      flag      <= 1'b0;
      cap_value <= '0;
      edge_pol  <= 1'b0;
    end else begin
      pin_s1    <= pin_in;                     // R20
      pin_s2    <= pin_s1;
      lin_s1    <= lin_in;
      lin_s2    <= lin_s1;
      prev      <= sel;
      flag      <= next_flag;
      cap_value <= next_cap_value;
      edge_pol  <= next_edge_pol;
    end
  end
endmodule

// File: core/frtc_timer.sv
// free-run timer with prescaler and four input capture channels
//
// Overview of operation
// R1: one 16-bit up counter, plus one per tick
// R2: prescaler divides clock, three-bit select, eight ratios
// R3: counter wrap raises overflow request
// R4: reset or clear bit forces counter to zero
// R5: live read; write loads only while stopped
// R6: four channels, own capture, shared counter
// R7: edge copies counter and raises request together
// R8: edge select rising, falling, both, none
// R9: each channel requests and enables independently
// R10: capture requests share one line, start service
// R11: overflow request own line, no service start
// R12: edge register shows polarity, selects source
// R13: channels 0,1 may use LIN; 2,3 pins
// R14: LIN trigger edges are timed for baud
// R15: two control registers, channel pairs 0-1, 2-3
// R16: external clock enable picks pin as count clock
// R17: stop bit zero runs, one halts counting
// R18: flag sets on edge, cleared by zero
// R19: capture registers read-only, hold until next edge
// R20: pins synchronised before edge detection
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
module frtc_timer
  import frtc_pkg::*;
#(
  parameter int CW    = 16,
  parameter int PRE_W = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        external_count_clock_in,
  input  wire logic        capture_input_0,
  input  wire logic        capture_input_1,
  input  wire logic        capture_input_2,
  input  wire logic        capture_input_3,
  input  wire logic        lin_serial_unit_0_trig,
  input  wire logic        lin_serial_unit_1_trig,
  output logic             irq_capture,
  output logic             irq_overflow,
  output logic             intelligent_io_service_req
);
  ////////////////////////////////////////////////////////////////////////
  // bus state
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        next_wr_pend;
  logic [7:0]  next_wr_addr;
  logic [31:0] next_hrdata;
  logic        take;

  // timer state
  logic [CW-1:0]    cnt;
  logic [PRE_W-1:0] pre;
  logic             ovf;
  logic             ovfe;
  logic             stop;
  logic [2:0]       cksel;
  logic             ext_clk_en;
  logic [3:0]       cap_ie;
  logic [7:0]       cap_eg;
  logic [1:0]       cap_src;
  logic             ext_s1;
  logic             ext_s2;
  logic             ext_s3;
  logic [CW-1:0]    next_cnt;
  logic [PRE_W-1:0] next_pre;
  logic             next_ovf;
  logic             next_ovfe;
  logic             next_stop;
  logic [2:0]       next_cksel;
  logic             next_ext_clk_en;
  logic [3:0]       next_cap_ie;
  logic [7:0]       next_cap_eg;
  logic [1:0]       next_cap_src;
  logic             next_irq_cap;
  logic             next_irq_ovf;
  logic             next_iio;

  // decode and timing terms
  logic             we_lo;
  logic             we_hi;
  logic             we_cnt;
  logic             we_ca;
  logic             we_cb;
  logic             we_ea;
  logic [PRE_W-1:0] pre_mask;
  logic             pre_tick;
  logic             tick;
  logic             wrap;
  logic [3:0]       flag_clr;

  // channel wires
  logic [3:0]    cap_pin;
  logic [3:0]    cap_lin;
  logic [3:0]    cap_use_lin;
  logic [3:0]    cap_flag;
  logic [3:0]    cap_pol;
  logic [3:0]    cap_hit;
  logic [CW-1:0] cap_val [FRTC_CH_NUM];

  assign cap_pin = {capture_input_3, capture_input_2,
                    capture_input_1, capture_input_0};
  // channels 2 and 3 have no LIN source
  assign cap_lin     = {2'b00, lin_serial_unit_1_trig,   // R13
                        lin_serial_unit_0_trig};
  assign cap_use_lin = {2'b00, cap_src};                 // R13

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states, always OKAY
  always_comb begin
    take         = hsel & hready & htrans[1];
    next_wr_pend = take & hwrite;
    next_wr_addr = take ? haddr[7:0] : wr_addr;
    next_hrdata  = hrdata;
    if (take && !hwrite) begin
      next_hrdata = '0;
      case (haddr[7:0])
        FRTC_OFS_CTRL_LO: begin
          next_hrdata[FRTC_BIT_OVF]  = ovf;
          next_hrdata[FRTC_BIT_OVFE] = ovfe;
          next_hrdata[FRTC_BIT_STOP] = stop;
          next_hrdata[FRTC_LSB_CKSEL+:3] = cksel;
        end
        FRTC_OFS_CTRL_HI: next_hrdata[FRTC_BIT_EXT_CLK] = ext_clk_en;
        FRTC_OFS_COUNT:   next_hrdata[CW-1:0] = cnt;     // R5
        FRTC_OFS_CAP_CTL_A: begin                        // R15
          next_hrdata[FRTC_LSB_FLAG+:2] = cap_flag[1:0];
          next_hrdata[FRTC_LSB_IE+:2]   = cap_ie[1:0];
          next_hrdata[FRTC_LSB_EDGE+:4] = cap_eg[3:0];
        end
        FRTC_OFS_CAP_CTL_B: begin                        // R15
          next_hrdata[FRTC_LSB_FLAG+:2] = cap_flag[3:2];
          next_hrdata[FRTC_LSB_IE+:2]   = cap_ie[3:2];
          next_hrdata[FRTC_LSB_EDGE+:4] = cap_eg[7:4];
        end
        FRTC_OFS_CAP_EDG_A: begin                        // R12
          next_hrdata[FRTC_LSB_POL+:2] = cap_pol[1:0];
          next_hrdata[FRTC_LSB_SRC+:2] = cap_src;
        end
        FRTC_OFS_CAP_EDG_B: next_hrdata[FRTC_LSB_POL+:2] = cap_pol[3:2];
        FRTC_OFS_CAP_VAL0: next_hrdata[CW-1:0] = cap_val[0]; // R19
        FRTC_OFS_CAP_VAL1: next_hrdata[CW-1:0] = cap_val[1];
        FRTC_OFS_CAP_VAL2: next_hrdata[CW-1:0] = cap_val[2];
        FRTC_OFS_CAP_VAL3: next_hrdata[CW-1:0] = cap_val[3];
        default:           next_hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter, prescaler and control registers
  always_comb begin
    we_lo  = wr_pend && (wr_addr == FRTC_OFS_CTRL_LO);
    we_hi  = wr_pend && (wr_addr == FRTC_OFS_CTRL_HI);
    we_cnt = wr_pend && (wr_addr == FRTC_OFS_COUNT);
    we_ca  = wr_pend && (wr_addr == FRTC_OFS_CAP_CTL_A);
    we_cb  = wr_pend && (wr_addr == FRTC_OFS_CAP_CTL_B);
    we_ea  = wr_pend && (wr_addr == FRTC_OFS_CAP_EDG_A);
    // ratio is two to the power of select plus one
    pre_mask = PRE_W'((2 << cksel) - 1);                 // R2
    pre_tick = (pre & pre_mask) == pre_mask;             // R2
    tick     = !stop && (ext_clk_en ? (ext_s2 & ~ext_s3) // R16 R17
                              : pre_tick);
    wrap     = tick && (cnt == FRTC_COUNT_MAX);
    next_pre = pre + 1'b1;

    next_cnt = cnt;
    if (we_lo && hwdata[FRTC_BIT_CLR])
      next_cnt = FRTC_COUNT_RST;                         // R4
    else if (we_cnt && stop)
      next_cnt = hwdata[CW-1:0];                         // R5
    else if (tick)
      next_cnt = cnt + 1'b1;                             // R1

    next_ovf   = wrap | (ovf & ~(we_lo & ~hwdata[FRTC_BIT_OVF])); // R3
    next_ovfe  = we_lo ? hwdata[FRTC_BIT_OVFE] : ovfe;
    next_stop  = we_lo ? hwdata[FRTC_BIT_STOP] : stop;   // R17
    next_cksel = we_lo ? hwdata[FRTC_LSB_CKSEL+:3] : cksel; // R2
    next_ext_clk_en = we_hi ? hwdata[FRTC_BIT_EXT_CLK] : ext_clk_en; // R16

    next_cap_ie  = cap_ie;
    next_cap_eg  = cap_eg;
    flag_clr     = 4'h0;
    for (int j = 0; j < 2; j++) begin                    // R15
      if (we_ca) begin
        next_cap_ie[j]       = hwdata[FRTC_LSB_IE+j];    // R9
        next_cap_eg[2*j+:2]  = hwdata[FRTC_LSB_EDGE+2*j+:2];
        flag_clr[j]          = ~hwdata[FRTC_LSB_FLAG+j]; // R18
      end
      if (we_cb) begin
        next_cap_ie[2+j]      = hwdata[FRTC_LSB_IE+j];
        next_cap_eg[4+2*j+:2] = hwdata[FRTC_LSB_EDGE+2*j+:2];
        flag_clr[2+j]         = ~hwdata[FRTC_LSB_FLAG+j];
      end
    end
    next_cap_src = we_ea ? hwdata[FRTC_LSB_SRC+:2] : cap_src; // R12

    next_irq_ovf = next_ovf & next_ovfe;                 // R3 R11
    next_irq_cap = |(cap_flag & cap_ie);                 // R10 R18
    // overflow never starts the service transfer
    next_iio     = |(cap_hit & cap_ie);                  // R10 R11
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt          <= FRTC_COUNT_RST;                    // R4
      pre          <= '0;
      ovf          <= 1'b0;
      ovfe         <= 1'b0;
      stop         <= 1'b0;
      cksel        <= FRTC_CKSEL_RST;
      ext_clk_en   <= 1'b0;
      cap_ie       <= 4'h0;
      cap_eg       <= 8'h00;
      cap_src      <= 2'h0;
      ext_s1       <= 1'b0;
      ext_s2       <= 1'b0;
      ext_s3       <= 1'b0;
      irq_overflow <= 1'b0;
      irq_capture  <= 1'b0;
      intelligent_io_service_req <= 1'b0;
    end else begin
      cnt          <= next_cnt;
      pre          <= next_pre;
      ovf          <= next_ovf;
      ovfe         <= next_ovfe;
      stop         <= next_stop;
      cksel        <= next_cksel;
      ext_clk_en   <= next_ext_clk_en;
      cap_ie       <= next_cap_ie;
      cap_eg       <= next_cap_eg;
      cap_src      <= next_cap_src;
      ext_s1       <= external_count_clock_in;
      ext_s2       <= ext_s1;
      ext_s3       <= ext_s2;
      irq_overflow <= next_irq_ovf;
      irq_capture  <= next_irq_cap;
      intelligent_io_service_req <= next_iio;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture channels
  for (genvar i = 0; i < FRTC_CH_NUM; i++) begin : g_ch  // R6
    frtc_capture_chan #(
      .W (CW)
    ) u_ch (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .pin_in    (cap_pin[i]),
      .lin_in    (cap_lin[i]),
      .use_lin   (cap_use_lin[i]),
      .edge_sel  (cap_eg[2*i+:2]),
      .count     (cnt),
      .flag_clr  (flag_clr[i]),
      .flag      (cap_flag[i]),
      .cap_value (cap_val[i]),
      .edge_pol  (cap_pol[i]),
      .hit       (cap_hit[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_clear_write;
    we_lo && hwdata[FRTC_BIT_CLR];
  endsequence

  sequence s_wrap_raise;
    ##1 ovf ##1 (irq_overflow == ovfe);
  endsequence

  cnt_clear_a: assert property (s_clear_write |=> cnt == '0) // R4
    else $error("counter not cleared by clear bit");

  cnt_load_a: assert property (                             // R5
    we_cnt && stop
    |=> cnt == $past(hwdata[CW-1:0]))
    else $error("stopped counter did not take written value");

  cnt_stop_a: assert property (                             // R17
    stop && !wr_pend |=> cnt == $past(cnt))
    else $error("counter moved while stopped");

  cnt_step_a: assert property (                             // R1
    tick && !wr_pend |=> cnt == CW'($past(cnt) + 1'b1))
    else $error("counter did not step by one");

  ovf_raise_a: assert property (                            // R3
    wrap && !wr_pend |-> s_wrap_raise)
    else $error("overflow flag or request missing after wrap");

  cap_copy_a: assert property (                             // R7
    cap_hit[0] |=> cap_val[0] == $past(cnt) && cap_flag[0])
    else $error("capture value or flag wrong after edge");

  cap_none_a: assert property (                             // R8
    cap_eg[1:0] == FRTC_EDGE_NONE |-> !cap_hit[0])
    else $error("capture fired with detection off");

  cap_hold_a: assert property (                             // R19
    !cap_hit[1] |=> cap_val[1] == $past(cap_val[1]))
    else $error("capture value changed without edge");

  flag_keep_a: assert property (                            // R18
    cap_flag[2] && !flag_clr[2] |=> cap_flag[2])
    else $error("capture flag lost without clear");

  irq_cap_a: assert property (                              // R9
    cap_flag[3] && cap_ie[3] |=> irq_capture)
    else $error("capture request missing");

  iio_src_a: assert property (                              // R11
    intelligent_io_service_req |-> $past(|(cap_hit & cap_ie)))
    else $error("service request without capture event");
endmodule

// File: bench/frtc_pulse_source.sv
// partner model: capture pins, LIN edge sources and external count clock
`timescale 1ns/100ps
module frtc_pulse_source (
  input  wire logic       hclk,
  output logic [3:0]      pins,
  output logic [1:0]      lin,
  output logic            ext_clk
);
  initial begin
    pins    = 4'h0;
    lin     = 2'h0;
    ext_clk = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic set_pin(input int ch, input logic v);
    @(posedge hclk);
    pins[ch] <= v;
  endtask
  // edge from a LIN serial unit, timed by channel 0 or 1
  task automatic set_lin(input int u, input logic v);
    @(posedge hclk);
    lin[u] <= v;
  endtask
  // kept far below half the bus clock so every edge is seen
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      ext_clk <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_clk <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask
endmodule

// File: bench/free_run_timer_input_capture_bench.sv
// self-checking bench for the free-run timer with input capture
`timescale 1ns/100ps
module free_run_timer_input_capture_bench;
  import frtc_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout;
  logic        hresp;
  logic        irq_capture;
  logic        irq_overflow;
  logic        svc_req;
  logic [3:0]  pins;
  logic [1:0]  lin;
  logic        ext_clk;
  logic [15:0] exp_cap [4];
  int          miscompares = 0;
  int          n_checks = 0;
  int          svc_count = 0;

  frtc_timer uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .external_count_clock_in(ext_clk),
    .capture_input_0(pins[0]), .capture_input_1(pins[1]),
    .capture_input_2(pins[2]), .capture_input_3(pins[3]),
    .lin_serial_unit_0_trig(lin[0]), .lin_serial_unit_1_trig(lin[1]),
    .irq_capture(irq_capture), .irq_overflow(irq_overflow),
    .intelligent_io_service_req(svc_req)
  );
  frtc_pulse_source pulse (
    .hclk(hclk), .pins(pins), .lin(lin), .ext_clk(ext_clk)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (svc_req === 1'b1) begin
      svc_count <= svc_count + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check_val(input string w, input logic [31:0] e,
                           input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask
  task automatic check_range(input string w, input int lo, input int hi,
                             input logic [31:0] g);
    n_checks++;
    if ($isunknown(g) || g < lo || g > hi) begin
      miscompares++;
      $display("unexpected %s: expected %0d..%0d seen %h", w, lo, hi, g);
    end
  endtask
  task automatic wait_ready();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin
      miscompares++;
      $display("unexpected hready: expected 1 seen %b", hreadyout);
      conclude();
    end
  endtask
  task automatic bus_addr(input logic [7:0] a, input logic w);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= FRTC_HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
  endtask
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    bus_addr(a, 1'b1);
    hwdata <= d;
    wait_ready();
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    bus_addr(a, 1'b0);
    wait_ready();
    d = hrdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    bus_read(FRTC_OFS_CTRL_LO, d);
    check_val("ctrl_low", 32'h0, d);
    bus_read(FRTC_OFS_CAP_CTL_A, d);
    check_val("cap_ctl_a", 32'h0, d);
    bus_read(8'h3C, d);
    check_val("unmapped", 32'h0, d);
    check_val("hresp", 32'h0, 32'(hresp));
    $display("test reset done");
  endtask
  task automatic t_count();
    logic [31:0] d;
    logic [31:0] d2;
    for (int s = 0; s < 8; s++) begin
      bus_write(FRTC_OFS_CTRL_LO, 32'h20 | 32'(s));
      bus_write(FRTC_OFS_COUNT, 32'h0);
      bus_write(FRTC_OFS_CTRL_LO, 32'(s));
      repeat (8 << (s + 1)) @(posedge hclk);
      bus_write(FRTC_OFS_CTRL_LO, 32'h20 | 32'(s));
      bus_read(FRTC_OFS_COUNT, d);
      check_range("prescaled count", 8, 10, d);
    end
    bus_read(FRTC_OFS_COUNT, d2);
    check_val("held count", d, d2);
    bus_write(FRTC_OFS_COUNT, 32'h1234);
    bus_read(FRTC_OFS_COUNT, d);
    check_val("loaded count", 32'h1234, d);
    bus_write(FRTC_OFS_CTRL_LO, 32'h28);
    bus_read(FRTC_OFS_COUNT, d);
    check_val("cleared count", 32'h0, d);
    bus_write(FRTC_OFS_CTRL_LO, 32'h0);
    bus_write(FRTC_OFS_COUNT, 32'hABCD);
    bus_write(FRTC_OFS_CTRL_LO, 32'h20);
    bus_read(FRTC_OFS_COUNT, d);
    check_range("running write", 1, 16, d);
    $display("test count done");
  endtask
  task automatic t_overflow();
    logic [31:0] d;
    int          base;
    base = svc_count;
    bus_write(FRTC_OFS_COUNT, 32'hFFFE);
    bus_write(FRTC_OFS_CTRL_LO, 32'h40);
    for (int i = 0; i < 40 && irq_overflow !== 1'b1; i++) @(posedge hclk);
    check_val("irq_overflow", 32'h1, 32'(irq_overflow));
    if (irq_overflow !== 1'b1) conclude();
    bus_read(FRTC_OFS_CTRL_LO, d);
    check_val("overflow flag", 32'hC0, d);
    bus_write(FRTC_OFS_CTRL_LO, 32'h20);
    bus_read(FRTC_OFS_COUNT, d);
    check_range("wrapped count", 0, 40, d);
    bus_read(FRTC_OFS_CTRL_LO, d);
    check_val("flag cleared", 32'h20, d);
    check_val("irq_overflow low", 32'h0, 32'(irq_overflow));
    check_val("service pulses", 32'(base), 32'(svc_count));
    $display("test overflow done");
  endtask
  task automatic t_capture();
    logic [31:0] d;
    logic [7:0]  ctl;
    logic [7:0]  edg;
    logic [7:0]  va;
    logic [15:0] v;
    logic        hit;
    int          j;
    int          base;
    base = svc_count;
    for (int ch = 0; ch < 4; ch++) begin
      j   = ch % 2;
      ctl = (ch < 2) ? FRTC_OFS_CAP_CTL_A : FRTC_OFS_CAP_CTL_B;
      edg = (ch < 2) ? FRTC_OFS_CAP_EDG_A : FRTC_OFS_CAP_EDG_B;
      va  = FRTC_OFS_CAP_VAL0 + 8'(4 * ch);
      for (int m = 0; m < 4; m++) begin
        for (int e = 1; e >= 0; e--) begin
          bus_write(ctl, (32'h10 << j) | (32'(m) << (2 * j)));
          v = 16'((m + 1) * 4096 + e * 2048 + ch);
          bus_write(FRTC_OFS_COUNT, 32'(v));
          pulse.set_pin(ch, 1'(e));
          repeat (6) @(posedge hclk);
          hit = (e == 1) ? (m % 2 == 1) : (m >= 2);
          if (hit) exp_cap[ch] = v;
          bus_read(ctl, d);
          check_val("capture flag", 32'(hit), 32'(d[6 + j]));
          check_val("irq_capture", 32'(hit), 32'(irq_capture));
          if (hit) begin
            bus_read(edg, d);
            check_val("polarity", 32'(e), 32'(d[j]));
          end
          if (m > 0) begin
            bus_read(va, d);
            check_val("capture value", 32'(exp_cap[ch]), d);
          end
        end
      end
      bus_write(ctl, 32'h0);
    end
    check_val("service pulses", 32'(base + 16), 32'(svc_count));
    for (int ch = 0; ch < 4; ch++) begin
      bus_write(FRTC_OFS_CAP_VAL0 + 8'(4 * ch), 32'h5A5A);
      bus_read(FRTC_OFS_CAP_VAL0 + 8'(4 * ch), d);
      check_val("read-only capture", 32'(exp_cap[ch]), d);
    end
    $display("test capture done");
  endtask
  task automatic t_lin();
    logic [31:0] d;
    for (int u = 0; u < 2; u++) begin
      bus_write(FRTC_OFS_CAP_EDG_A, 32'h4 << u);
      bus_write(FRTC_OFS_CAP_CTL_A, (32'h10 << u) | (32'h1 << (2 * u)));
      bus_write(FRTC_OFS_COUNT, 32'h7770 + 32'(u));
      pulse.set_pin(u, 1'b1);
      repeat (6) @(posedge hclk);
      bus_read(FRTC_OFS_CAP_CTL_A, d);
      check_val("pin ignored", 32'h0, 32'(d[6 + u]));
      pulse.set_lin(u, 1'b1);
      repeat (6) @(posedge hclk);
      bus_read(FRTC_OFS_CAP_CTL_A, d);
      check_val("lin flag", 32'h1, 32'(d[6 + u]));
      bus_read(FRTC_OFS_CAP_VAL0 + 8'(4 * u), d);
      check_val("lin capture", 32'h7770 + 32'(u), d);
      bus_write(FRTC_OFS_CAP_CTL_A, 32'h0);
      bus_write(FRTC_OFS_CAP_EDG_A, 32'h0);
    end
    $display("test lin done");
  endtask
  task automatic t_extclk();
    logic [31:0] d;
    bus_write(FRTC_OFS_COUNT, 32'h0);
    bus_write(FRTC_OFS_CTRL_HI, 32'h8000);
    bus_read(FRTC_OFS_CTRL_HI, d);
    check_val("ctrl_high", 32'h8000, d);
    bus_write(FRTC_OFS_CTRL_LO, 32'h0);
    pulse.ext_pulses(5);
    repeat (4) @(posedge hclk);
    bus_write(FRTC_OFS_CTRL_LO, 32'h20);
    bus_read(FRTC_OFS_COUNT, d);
    check_val("external count", 32'h5, d);
    bus_write(FRTC_OFS_CTRL_HI, 32'h0);
    $display("test external clock done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge hclk);
    miscompares++;
    $display("unexpected run length: expected end seen timeout");
    conclude();
  end
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_count();
    t_overflow();
    t_capture();
    t_lin();
    t_extclk();
    conclude();
  end
endmodule
